/* lvd_modes.sv */
// Low-voltage detector control core for interrupt and interrupt-then-reset modes
//
// Overview of operation
// R01 - Interrupt-only option code starts the level register at 01H.
// R02 - Combined option code starts the level register at 00H.
// R03 - Combined mode: level bit 0 compares high threshold, 1 compares low.
// R04 - Rewrite-enable bit 7 starts at 0, so level register is locked.
// R05 - Interrupt-only: hold reset until supply exceeds the single threshold.
// R06 - Interrupt-only: after release, threshold crossings raise the interrupt.
// R07 - Every reset sets the interrupt mask; firmware clears it.
// R08 - Combined: hold reset after power-up until supply exceeds high threshold.
// R09 - Combined: interrupt when supply drops below the high threshold.
// R10 - Combined: after the interrupt, reset when supply drops below low threshold.
// R11 - Combined: no second interrupt on recovery without passing the low threshold.
// R12 - Firmware waits 400 us or 5 slow clocks after a detector reset.
// R13 - Firmware sets rewrite-enable during the wait and mode rewrites, masking events.
// R14 - Firmware clears the mode bit after the wait.
// R15 - Mode bit 1 at mask release with supply below high threshold resets.
// R16 - No reset after release means supply is fine; firmware clears mode bit.
// R17 - Combined: hardware switches mode and level bits; firmware writes only 0.
// R18 - Output-mask status set in combined mode while masked or settling.
// R19 - Detection flag is 1 below selected threshold, else 0, and 0 when off.
// R20 - Level register writes take effect only while rewrite-enable is 1.
// R21 - Interrupt flag set once per crossing, cleared by firmware, no retrigger.
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lvd_defines.svh"
module lvd_modes
  import lvd_pkg::*;
(
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Comparator results, asynchronous: 1 means supply is below that threshold
  input  wire logic               below_high_threshold,
  input  wire logic               below_low_threshold,
  input  wire logic               below_single_threshold,
  // Option byte mode code, static after power-up
  input  wire logic               opt_mode_sel_hi,
  input  wire logic               opt_mode_sel_lo,
  // Low-speed oscillator, sampled as data
  input  wire logic               low_speed_clk,
  // Register bus
  input  wire logic [`LVD_AW-1:0] s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [`LVD_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [`LVD_AW-1:0] s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [`LVD_DW-1:0]      s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Requests to the rest of the chip
  output logic                    detector_reset_req,
  output logic                    low_voltage_irq
);
  localparam int PINS = 6;
  localparam logic [7:0] INIT_INT = `LVD_LVL_INIT_INT, INIT_CMB = `LVD_LVL_INIT_CMB;

  lvd_reg_if rif ();

  logic [PINS-1:0] sync1_r;
  logic [PINS-1:0] sync2_r;
  logic [PINS-1:0] pin_raw;
  logic            lsclk_d_r;
  lvd_state_e      state_r;
  lvd_mode_e       mode_r;
  logic [1:0]      init_cnt_r;
  logic            detect_mode_bit_r;
  logic            detect_level_bit_r;
  logic            level_rewrite_enable_r;
  logic            settle_r;
  logic [2:0]      settle_cnt_r;
  logic            low_voltage_irq_flag_r;
  logic            low_voltage_irq_mask_r;
  logic            detector_reset_flag_r;
  logic            below_threshold_flag_r;
  logic            output_mask_status_r;
  logic            single_prev_r;
  logic            below_high;
  logic            below_low;
  logic            below_single;
  logic            lsclk_s;
  logic [1:0]      opt_code;
  logic            sel_below;
  logic            masked;
  logic            running;
  logic            cmb_irq_ev;
  logic            cmb_rst_ev;
  logic            int_irq_ev;
  logic            irq_ev;
  logic            hold_release;
  logic            wr_fire;
  lvd_sel_e        wr_sel;
  lvd_sel_e        rd_sel;
  logic            lvl_wr;
  logic            lvl_new;
  logic            mode_new;

  // Bus slave; its AXI outputs are its own flops
  lvd_axil_slave u_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rif           (rif.bus)
  );

  // Two-stage synchronisers; only stage two is read by logic
  assign pin_raw = {low_speed_clk, opt_mode_sel_hi, opt_mode_sel_lo,
                    below_single_threshold, below_low_threshold, below_high_threshold};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  assign {lsclk_s, opt_code, below_single, below_low, below_high} = sync2_r;

  // Compared threshold and event conditions
  assign sel_below    = (mode_r == LVD_MODE_INT) ? below_single :
                        (detect_level_bit_r ? below_low : below_high); // R03
  assign masked       = level_rewrite_enable_r | settle_r; // R13
  assign running      = (state_r == LVD_ST_RUN);
  // Interrupt only from interrupt setting at the high level; mode 1 blocks a repeat
  assign cmb_irq_ev   = running & (mode_r == LVD_MODE_CMB) & ~masked & ~detect_mode_bit_r &
                        ~detect_level_bit_r & below_high; // R09 R11
  // Reset setting trips on whichever threshold the level bit selects
  assign cmb_rst_ev   = running & (mode_r == LVD_MODE_CMB) & ~masked & detect_mode_bit_r &
                        sel_below; // R10 R15
  assign int_irq_ev   = running & (mode_r == LVD_MODE_INT) &
                        (below_single != single_prev_r); // R06
  assign irq_ev       = cmb_irq_ev | int_irq_ev;
  assign hold_release = (state_r == LVD_ST_HOLD) &
                        ((mode_r == LVD_MODE_INT) ? ~below_single : // R05
                         (mode_r == LVD_MODE_CMB) ? ~below_high : 1'b1); // R08

  // Register write decode
  assign wr_fire  = rif.wr_en & rif.wr_lane0;
  assign wr_sel   = lvd_reg_sel(rif.wr_addr);
  assign rd_sel   = lvd_reg_sel(rif.rd_addr);
  assign lvl_wr   = wr_fire & (wr_sel == LVD_SEL_LEVEL) & (mode_r == LVD_MODE_CMB) &
                    level_rewrite_enable_r; // R20
  // Firmware can only clear these bits, never set them
  assign mode_new = detect_mode_bit_r & rif.wr_data[`LVD_LVL_MODE_BIT]; // R17
  assign lvl_new  = detect_level_bit_r & rif.wr_data[`LVD_LVL_LEVEL_BIT]; // R17
  assign rif.wr_hit = (wr_sel != LVD_SEL_NONE);
  assign rif.rd_hit = (rd_sel != LVD_SEL_NONE);

  // Sequencer: capture option code, hold reset, run, re-enter hold on a detector reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r            <= LVD_ST_INIT;
      mode_r             <= LVD_MODE_OFF;
      init_cnt_r         <= 2'h0;
      detector_reset_req <= 1'b1;
    end else begin
      case (state_r)
        LVD_ST_INIT: begin
          init_cnt_r <= init_cnt_r + 2'h1;
          // Wait until the synchronised option code has settled
          if (init_cnt_r == `LVD_INIT_WAIT) begin
            state_r <= LVD_ST_HOLD;
            if (opt_code == `LVD_OPT_INT) begin
              mode_r <= LVD_MODE_INT;
            end else if (opt_code == `LVD_OPT_CMB) begin
              mode_r <= LVD_MODE_CMB;
            end else begin
              mode_r <= LVD_MODE_OFF;
            end
          end
        end
        LVD_ST_HOLD: begin
          if (hold_release) begin
            state_r            <= LVD_ST_RUN;
            detector_reset_req <= 1'b0; // R05 R08
          end
        end
        LVD_ST_RUN: begin
          if (cmb_rst_ev) begin
            state_r            <= LVD_ST_HOLD;
            detector_reset_req <= 1'b1; // R10 R15
          end
        end
        default: begin
          state_r <= LVD_ST_INIT;
        end
      endcase
    end
  end

  // Level register: start value from the option code, then hardware switching
  // A detector reset loads mode bit 1 and level bit 0 here; only the chip reset reloads the start value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_mode_bit_r  <= INIT_CMB[`LVD_LVL_MODE_BIT];
      detect_level_bit_r <= INIT_CMB[`LVD_LVL_LEVEL_BIT];
    end else if (state_r == LVD_ST_INIT && init_cnt_r == `LVD_INIT_WAIT) begin
      if (opt_code == `LVD_OPT_INT) begin
        detect_mode_bit_r  <= INIT_INT[`LVD_LVL_MODE_BIT]; // R01
        detect_level_bit_r <= INIT_INT[`LVD_LVL_LEVEL_BIT]; // R01
      end else begin
        detect_mode_bit_r  <= INIT_CMB[`LVD_LVL_MODE_BIT]; // R02
        detect_level_bit_r <= INIT_CMB[`LVD_LVL_LEVEL_BIT]; // R02
      end
    end else if (cmb_rst_ev) begin
      detect_mode_bit_r  <= 1'b1; // R17
      detect_level_bit_r <= 1'b0; // R17
    end else if (cmb_irq_ev) begin
      detect_mode_bit_r  <= 1'b1; // R17
      detect_level_bit_r <= 1'b1; // R17
    end else if (lvl_wr) begin
      detect_mode_bit_r  <= mode_new; // R20
      detect_level_bit_r <= lvl_new; // R20
    end
  end

  // Rewrite enable: settable only in combined mode, kept across a detector reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_rewrite_enable_r <= 1'b0; // R04
    end else if (wr_fire && wr_sel == LVD_SEL_CTRL && mode_r == LVD_MODE_CMB) begin
      level_rewrite_enable_r <= rif.wr_data[`LVD_CTRL_REN_BIT];
    end
  end

  // Threshold settling after an interrupt or a level change, timed on the slow clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lsclk_d_r    <= 1'b0;
      settle_r     <= 1'b0;
      settle_cnt_r <= 3'h0;
    end else begin
      lsclk_d_r <= lsclk_s;
      if (cmb_irq_ev || (lvl_wr && lvl_new != detect_level_bit_r)) begin
        settle_r     <= 1'b1; // R18
        settle_cnt_r <= 3'h0;
      end else if (settle_r && lsclk_s && !lsclk_d_r) begin
        settle_cnt_r <= settle_cnt_r + 3'h1;
        if (settle_cnt_r == `LVD_STAB_LS_CYC - 3'h1) begin
          settle_r <= 1'b0;
        end
      end
    end
  end

  // Interrupt flag and mask; a new event beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_voltage_irq_flag_r <= 1'b0;
      low_voltage_irq_mask_r <= 1'b1; // R07
      single_prev_r          <= 1'b0;
    end else begin
      single_prev_r <= below_single;
      if (irq_ev) begin
        low_voltage_irq_flag_r <= 1'b1; // R21
      end else if (wr_fire && wr_sel == LVD_SEL_IRQ && rif.wr_data[`LVD_IRQ_FLAG_BIT]) begin
        low_voltage_irq_flag_r <= 1'b0;
      end
      if (cmb_rst_ev) begin
        low_voltage_irq_mask_r <= 1'b1; // R07
      end else if (wr_fire && wr_sel == LVD_SEL_IRQ) begin
        low_voltage_irq_mask_r <= rif.wr_data[`LVD_IRQ_MASK_BIT];
      end
    end
  end

  // Detector reset flag, write one to clear, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detector_reset_flag_r <= 1'b0;
    end else if (cmb_rst_ev) begin
      detector_reset_flag_r <= 1'b1;
    end else if (wr_fire && wr_sel == LVD_SEL_IRQ && rif.wr_data[`LVD_IRQ_DRF_BIT]) begin
      detector_reset_flag_r <= 1'b0;
    end
  end

  // Status flags and the masked interrupt output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      below_threshold_flag_r <= 1'b0;
      output_mask_status_r   <= 1'b0;
      low_voltage_irq        <= 1'b0;
    end else begin
      below_threshold_flag_r <= (state_r != LVD_ST_INIT) && (mode_r != LVD_MODE_OFF) &&
                                sel_below; // R19
      output_mask_status_r   <= (mode_r == LVD_MODE_CMB) && masked; // R18
      low_voltage_irq        <= low_voltage_irq_flag_r & ~low_voltage_irq_mask_r; // R07
    end
  end

  // Read mux; unused bits read as zero
  always_comb begin
    rif.rd_data = '0;
    if (rd_sel == LVD_SEL_CTRL) begin
      rif.rd_data[`LVD_CTRL_REN_BIT]  = level_rewrite_enable_r;
      rif.rd_data[`LVD_CTRL_OMSK_BIT] = output_mask_status_r;
      rif.rd_data[`LVD_CTRL_BTF_BIT]  = below_threshold_flag_r;
    end else if (rd_sel == LVD_SEL_LEVEL) begin
      rif.rd_data[`LVD_LVL_MODE_BIT]  = detect_mode_bit_r;
      rif.rd_data[`LVD_LVL_LEVEL_BIT] = detect_level_bit_r;
    end else if (rd_sel == LVD_SEL_IRQ) begin
      rif.rd_data[`LVD_IRQ_MASK_BIT]   = low_voltage_irq_mask_r;
      rif.rd_data[`LVD_IRQ_FLAG_BIT]   = low_voltage_irq_flag_r;
      rif.rd_data[`LVD_IRQ_DRF_BIT]    = detector_reset_flag_r;
      rif.rd_data[`LVD_IRQ_OPT_LO_BIT] = (mode_r == LVD_MODE_INT);
      rif.rd_data[`LVD_IRQ_OPT_HI_BIT] = (mode_r == LVD_MODE_CMB);
    end
  end
endmodule : lvd_modes
`default_nettype wire

/* lvd_defines.svh */
// Named offsets, field positions, reset values and counts of the low-voltage detector block
`ifndef LVD_DEFINES_SVH
`define LVD_DEFINES_SVH

// Register bus geometry
`define LVD_AW             8
`define LVD_DW             32
`define LVD_OFS_CTRL       8'h00
`define LVD_OFS_LEVEL      8'h04
`define LVD_OFS_IRQ        8'h08
`define LVD_RESP_OKAY      2'h0
`define LVD_RESP_SLVERR    2'h2

// Detection control register fields
`define LVD_CTRL_REN_BIT   7
`define LVD_CTRL_OMSK_BIT  1
`define LVD_CTRL_BTF_BIT   0

// Detection level register fields and start values
`define LVD_LVL_MODE_BIT   7
`define LVD_LVL_LEVEL_BIT  0
`define LVD_LVL_INIT_INT   8'h01
`define LVD_LVL_INIT_CMB   8'h00

// Interrupt and flag register fields
`define LVD_IRQ_MASK_BIT   0
`define LVD_IRQ_FLAG_BIT   1
`define LVD_IRQ_DRF_BIT    2
`define LVD_IRQ_OPT_LO_BIT 4
`define LVD_IRQ_OPT_HI_BIT 5

// Option byte mode codes {hi, lo}
`define LVD_OPT_INT        2'h1
`define LVD_OPT_CMB        2'h2

// Timing counts
`define LVD_STAB_LS_CYC    3'h5
`define LVD_INIT_WAIT      2'h3

`endif

/* lvd_pkg.sv */
// Types and shared decode for the low-voltage detector block
`default_nettype none
package lvd_pkg;
  `include "lvd_defines.svh"

  typedef enum logic [1:0] {LVD_ST_INIT, LVD_ST_HOLD, LVD_ST_RUN}     lvd_state_e;
  typedef enum logic [1:0] {LVD_MODE_OFF, LVD_MODE_INT, LVD_MODE_CMB} lvd_mode_e;
  typedef enum logic [1:0] {LVD_SEL_CTRL, LVD_SEL_LEVEL, LVD_SEL_IRQ, LVD_SEL_NONE} lvd_sel_e;

  // Register select from a byte address; shared by read and write decode
  function automatic lvd_sel_e lvd_reg_sel(input logic [`LVD_AW-1:0] a);
    lvd_sel_e s;
    s = LVD_SEL_NONE;
    if (a == `LVD_OFS_CTRL) begin
      s = LVD_SEL_CTRL;
    end else if (a == `LVD_OFS_LEVEL) begin
      s = LVD_SEL_LEVEL;
    end else if (a == `LVD_OFS_IRQ) begin
      s = LVD_SEL_IRQ;
    end
    return s;
  endfunction : lvd_reg_sel
endpackage : lvd_pkg
`default_nettype wire

/* lvd_reg_if.sv */
// Register access carrier between the bus slave and the detector core
`timescale 1ns/1ps
`default_nettype none
`include "lvd_defines.svh"
interface lvd_reg_if;
  import lvd_pkg::*;
  logic                wr_en;
  logic                wr_lane0;
  logic [`LVD_AW-1:0]  wr_addr;
  logic [7:0]          wr_data;
  logic                wr_hit;
  logic [`LVD_AW-1:0]  rd_addr;
  logic [`LVD_DW-1:0]  rd_data;
  logic                rd_hit;

  modport bus  (output wr_en, wr_lane0, wr_addr, wr_data, rd_addr,
                input  wr_hit, rd_data, rd_hit);
  modport regs (input  wr_en, wr_lane0, wr_addr, wr_data, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface : lvd_reg_if
`default_nettype wire

/* lvd_axil_slave.sv */
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none
`include "lvd_defines.svh"
module lvd_axil_slave
  import lvd_pkg::*;
(
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Write address and data
  input  wire logic [`LVD_AW-1:0] s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [`LVD_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // Write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // Read
  input  wire logic [`LVD_AW-1:0] s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [`LVD_DW-1:0]      s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Register side
  lvd_reg_if.bus                  rif
);
  logic               aw_held_r;
  logic               w_held_r;
  logic [`LVD_AW-1:0] awaddr_r;
  logic [7:0]         wbyte_r;
  logic               wlane0_r;
  logic               commit;

  // Write fires once both halves are held and no response is pending
  assign commit       = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign rif.wr_en    = commit;
  assign rif.wr_addr  = awaddr_r;
  assign rif.wr_data  = wbyte_r;
  assign rif.wr_lane0 = wlane0_r;
  assign rif.rd_addr  = s_axi_araddr;

  // Write channels: address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= '0;
      wbyte_r       <= 8'h00;
      wlane0_r      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LVD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r      <= s_axi_awaddr;
        aw_held_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wbyte_r      <= s_axi_wdata[7:0]; // All fields live in byte lane 0
        wlane0_r     <= s_axi_wstrb[0];
        w_held_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (commit) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= rif.wr_hit ? `LVD_RESP_OKAY : `LVD_RESP_SLVERR;
      end
      // Ready returns only after the response, so one write is in flight
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read channel: data registered on the same edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `LVD_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata   <= rif.rd_data;
        s_axi_rresp   <= rif.rd_hit ? `LVD_RESP_OKAY : `LVD_RESP_SLVERR;
        s_axi_rvalid  <= 1'b1;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : lvd_axil_slave
`default_nettype wire

/* lvd_modes_assertions.sv */
// Concurrent checks on the low-voltage detector top ports
`timescale 1ns/1ps
`default_nettype none
module lvd_modes_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Detector side
  input wire logic below_high_threshold,
  input wire logic below_single_threshold,
  input wire logic opt_mode_sel_hi,
  input wire logic opt_mode_sel_lo,
  input wire logic detector_reset_req,
  input wire logic low_voltage_irq,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  logic wr_seen_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Firmware can unmask no earlier than its first accepted write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_seen_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      wr_seen_r <= 1'b1;
    end
  end
  hold_reset_a: assert property (disable iff (1'b0)
    !aresetn |=> detector_reset_req && !low_voltage_irq) else $error("reset state not held");
  irq_mask_a: assert property ($rose(low_voltage_irq) |-> wr_seen_r)
    else $error("interrupt raised while still masked");
  int_hold_a: assert property (!opt_mode_sel_hi && opt_mode_sel_lo && detector_reset_req
    && below_single_threshold && $past(below_single_threshold, 2) |=> detector_reset_req)
    else $error("single threshold hold released early");
  int_release_a: assert property (
    (!opt_mode_sel_hi && opt_mode_sel_lo && !below_single_threshold)[*8] |=> !detector_reset_req)
    else $error("single threshold hold not released");
  cmb_hold_a: assert property (opt_mode_sel_hi && !opt_mode_sel_lo && detector_reset_req
    && below_high_threshold && $past(below_high_threshold, 2) |=> detector_reset_req)
    else $error("high threshold hold released early");
  cmb_cause_a: assert property ($rose(detector_reset_req) |-> opt_mode_sel_hi
    && !opt_mode_sel_lo && $past(below_high_threshold, 3)) else $error("reset without cause");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write response late");
  wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not retired");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
endmodule : lvd_modes_assertions
bind lvd_modes lvd_modes_assertions i_chk (.*);
`default_nettype wire

/* lvd_supply_model.sv */
// Supply comparators and low-speed oscillator seen by the detector
`timescale 1ns/1ps
`default_nettype none
module lvd_supply_model (
  // Supply zone: 0 above high, 1 between thresholds, 2 below low
  input  wire logic [1:0] zone,
  // Comparator and oscillator outputs
  output logic            below_high_threshold,
  output logic            below_low_threshold,
  output logic            below_single_threshold,
  output logic            low_speed_clk
);
  // Single threshold sits with the high one so both modes share zones
  assign below_high_threshold   = (zone != 2'h0);
  assign below_low_threshold    = (zone == 2'h2);
  assign below_single_threshold = (zone != 2'h0);
  // Free-running slow oscillator, phase unrelated to aclk
  initial begin
    low_speed_clk = 1'b0;
    forever #30.3 low_speed_clk = ~low_speed_clk;
  end
endmodule : lvd_supply_model
`default_nettype wire

/* lvd_modes_tb_top.sv */
// Self-checking bench for the low-voltage detector control core
`timescale 1ns/1ps
`default_nettype none
`include "lvd_defines.svh"
module lvd_modes_tb_top;
  localparam logic [7:0] RC = `LVD_OFS_CTRL, RL = `LVD_OFS_LEVEL, RI = `LVD_OFS_IRQ;
  logic        aclk, aresetn, opt_mode_sel_hi, opt_mode_sel_lo, low_speed_clk;
  logic        below_high_threshold, below_low_threshold, below_single_threshold;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        detector_reset_req, low_voltage_irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, zone, rrsp;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  int          fails, checked;
  lvd_modes i_dut (.*);
  lvd_supply_model i_supply (.*);
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask : cy
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : pin
  // Address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, 32'h0);
        return;
      end
    end
    fails++;
    wrap_up();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        rdat = s_axi_rdata;
        rrsp = s_axi_rresp;
        return;
      end
    end
    fails++;
    wrap_up();
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rdat & m, e);
  endtask : rc
  task automatic rst(input logic [1:0] o);
    aresetn <= 1'b0;
    {opt_mode_sel_hi, opt_mode_sel_lo} <= o;
    cy(5);
    aresetn <= 1'b1;
  endtask : rst
  // Free-running system clock, 4 ns period
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Interrupt-only pass, then combined pass
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hf;
    {fails, checked, aresetn, zone} = 1;
    rst(2'h1);
    cy(20);
    pin(detector_reset_req, 1'b1);
    rc(RL, 32'hff, 32'h01);
    rc(RC, 32'h81, 32'h01);
    rc(RI, 32'h31, 32'h11);
    zone <= 2'h0;
    cy(12);
    pin(detector_reset_req, 1'b0);
    wr(RL, 8'h00);
    rc(RL, 32'hff, 32'h01);
    wr(RI, 8'h00);
    zone <= 2'h1;
    cy(12);
    pin(low_voltage_irq, 1'b1);
    wr(RI, 8'h02);
    cy(12);
    pin(low_voltage_irq, 1'b0);
    rd(8'h0c);
    chk(rdat, 32'h0);
    chk({30'h0, rrsp}, {30'h0, `LVD_RESP_SLVERR});
    rst(2'h2);
    cy(20);
    pin(detector_reset_req, 1'b1);
    zone <= 2'h0;
    cy(12);
    pin(detector_reset_req, 1'b0);
    rc(RL, 32'hff, 32'h00);
    rc(RC, 32'h83, 32'h00);
    wr(RI, 8'h00);
    zone <= 2'h1;
    cy(12);
    pin(low_voltage_irq, 1'b1);
    rc(RC, 32'h02, 32'h02);
    rc(RL, 32'hff, 32'h81);
    wr(RI, 8'h02);
    cy(100);
    rc(RC, 32'h03, 32'h00);
    zone <= 2'h0;
    cy(12);
    pin(low_voltage_irq, 1'b0);
    zone <= 2'h2;
    cy(12);
    pin(detector_reset_req, 1'b1);
    rc(RL, 32'hff, 32'h80);
    rc(RI, 32'h27, 32'h25);
    zone <= 2'h0;
    cy(12);
    wr(RI, 8'h04);
    wr(RC, 8'h80);
    zone <= 2'h1;
    cy(12);
    pin(detector_reset_req, 1'b0);
    wr(RC, 8'h00);
    cy(12);
    pin(detector_reset_req, 1'b1);
    zone <= 2'h0;
    cy(12);
    wr(RC, 8'h80);
    cy(100);
    wr(RL, 8'h00);
    rc(RL, 32'hff, 32'h00);
    wr(RC, 8'h00);
    cy(100);
    pin(detector_reset_req, 1'b0);
    wrap_up();
  end
endmodule : lvd_modes_tb_top
`default_nettype wire
